// >>> verilog/tofp_pkg.sv
// constants and types of the two-wire serial slave port
// assumes a 20 MHz system clock on clock_i
package tofp_pkg;

    localparam int CLK_FREQ_HZ     = 20_000_000;
    localparam int CLK_PERIOD_NS   = 50;
    // longest allowed low phase of the serial clock
    localparam int SCLK_LOW_MAX_NS = 1_000_000;
    localparam int SCLK_LOW_CYC    = SCLK_LOW_MAX_NS / CLK_PERIOD_NS;
    // highest serial clock rate the link is specified for
    localparam int SCLK_MAX_HZ     = 10_000_000;

    // emitter modulation square wave
    localparam int MOD_FREQ_HZ     = 10_000_000;
    localparam int MOD_HALF_CYC    = CLK_FREQ_HZ / (2 * MOD_FREQ_HZ);

    // frame layout, most significant bit first
    localparam int CMD_BITS        = 8;
    localparam int RESP_BITS       = 16;
    localparam int CMD_CODE_MSB    = 7;
    localparam int CMD_CODE_LSB    = 4;
    localparam int CMD_INT_MSB     = 3;
    localparam int CMD_INT_LSB     = 0;
    localparam int CMD_FIELD_W     = 4;

    localparam int RESP_FIFO_DEPTH = 16;

    localparam logic [CMD_FIELD_W-1:0] CMD_FIELD_RST = 4'h0;
    localparam logic [RESP_BITS-1:0]   RESP_RST      = 16'h0000;
    localparam logic [4:0]             BIT_CNT_RST   = 5'h00;

    typedef enum logic [2:0] {
        TOFP_IDLE     = 3'b000,
        TOFP_TX_START = 3'b001,
        TOFP_TX       = 3'b011,
        TOFP_RX       = 3'b010,
        TOFP_ERROR    = 3'b110
    } tofp_state_t;

endpackage

// >>> verilog/tofp_stream_if.sv
// valid/ready word stream between the port's own modules
// assumes one clock domain on both ends
`timescale 1ns/100ps
interface tofp_stream_if #(
    parameter int WIDTH = 16
) ();
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// >>> verilog/tofp_sync.sv
// two-flop synchroniser for a group of asynchronous levels
// assumes inputs arrive from pins outside clock_i's domain
`timescale 1ns/100ps
module tofp_sync #(
    parameter int               WIDTH   = 2,
    parameter logic [WIDTH-1:0] RST_VAL = '1
) (
    input  wire logic             clock_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;
endmodule // tofp_sync

// >>> verilog/tofp_fifo.sv
// synchronous fifo with valid/ready on both sides and a flush
// assumes one clock; flush wins over a write in the same cycle
`timescale 1ns/100ps
module tofp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic   clock_i,
    input  wire logic   rst_i,
    input  wire logic   flush_i,
    tofp_stream_if.snk  in_s,
    tofp_stream_if.src  out_s
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_reg;
    logic [AW:0]      rd_ptr_reg;

    wire full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    wire empty = (wr_ptr_reg == rd_ptr_reg);
    wire push  = in_s.valid && !full;
    wire pop   = out_s.ready && !empty;

    assign in_s.ready  = !full;
    assign out_s.valid = !empty;
    assign out_s.data  = mem[rd_ptr_reg[AW-1:0]];

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_s.data;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else if (flush_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
            rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
        end
    end
endmodule // tofp_fifo

// >>> verilog/tofp_port.sv
// two-wire serial slave port of a range-finder chip, with emitter modulation output
// assumes an external pull-up on the data line and on the emitter output; the host owns the clock
// Contract
// (R1) Single slave on the link; host is the only master.
// (R2) Link works with serial clock up to ten megahertz; responses need each clock low phase to last over three clock_i cycles.
// (R3) Host alone drives the serial clock; device only observes it.
// (R4) Host never holds the serial clock low for one millisecond or more.
// (R5) Clock low beyond one millisecond fully resets the device and interface.
// (R6) Parties only pull data low or release it; pull-up gives high.
// (R7) Wired-OR outputs on data line; direction decides who pulls low.
// (R8) After a communication error device holds data low until interface reset.
// (R9) When idle both parties release clock and data lines.
// (R10) Sender opens a transfer with data low while clock is high.
// (R11) Host then generates exactly the clock cycles the transfer needs.
// (R12) Sender changes data after falling edge; receiver samples on rising edge.
// (R13) Sender releases data after the final rising edge.
// (R14) Device is half-duplex: receiving or transmitting, never both.
// (R15) Run-time settings apply immediately and are lost on reset.
// (R16) Emitter modulation output is a square wave.
// (R17) Emitter output is open-drain, low means light on.
// (R18) Command frame: eight bits, MSB first, code high nibble, integration low nibble.
// (R19) Response frame: sixteen bits, MSB first, sent after processing.
// (R20) Clock low phase timed by internal counter; reset once threshold exceeded.
`timescale 1ns/100ps
module tofp_port
    import tofp_pkg::*;
#(
    parameter int SCLK_LOW_LIMIT = SCLK_LOW_CYC,
    parameter int FIFO_DEPTH     = RESP_FIFO_DEPTH,
    parameter int MOD_HALF       = MOD_HALF_CYC
) (
    input  wire logic                   clock_i,
    input  wire logic                   rst_i,
    // serial link pins
    input  wire logic                   sclk_i,
    input  wire logic                   serial_data_line_in_i,
    output logic                        serial_data_line_out_o,
    output logic                        serial_data_line_oe_o,
    // emitter modulation pin
    output logic                        emitter_drive_output_out_o,
    output logic                        emitter_drive_output_oe_o,
    input  wire logic                   illuminate_i,
    // received command
    output logic                        cmd_valid_o,
    output logic [CMD_FIELD_W-1:0]      cmd_code_o,
    output logic [CMD_FIELD_W-1:0]      cmd_int_o,
    // responses to send
    input  wire logic                   resp_valid_i,
    input  wire logic [RESP_BITS-1:0]   resp_data_i,
    output logic                        resp_ready_o,
    // status
    output logic                        dev_reset_o,
    output logic                        link_error_o
);
    localparam int CW = $clog2(SCLK_LOW_LIMIT + 2);
    localparam int MW = $clog2(MOD_HALF + 1);
    localparam logic [CW-1:0] LOW_LIMIT_W = CW'(SCLK_LOW_LIMIT);
    localparam logic [MW-1:0] MOD_LAST_W  = MW'(MOD_HALF - 1);
    localparam logic [4:0]    CMD_LAST_W  = 5'(CMD_BITS - 1);
    localparam logic [4:0]    RESP_LAST_W = 5'(RESP_BITS - 1);

    // pin sampling; the port only watches the clock, never drives it [R3]
    logic [1:0] pins_s;
    logic       sclk_s;
    logic       sda_s;

    // sampled at 20 MHz; each clock phase must span at least one sample period [R2]
    tofp_sync #(
        .WIDTH   (2),
        .RST_VAL (2'h3)
    ) u_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .async_i ({sclk_i, serial_data_line_in_i}),
        .sync_o  (pins_s)
    );

    assign sclk_s = pins_s[1];
    assign sda_s  = pins_s[0];

    tofp_state_t            state_reg;
    tofp_state_t            state_next;
    logic                   sclk_d_reg;
    logic                   sda_d_reg;
    logic [CW-1:0]          low_cnt_reg;
    logic                   link_rst_reg;
    logic [4:0]             bit_cnt_reg;
    logic [4:0]             bit_cnt_next;
    logic [RESP_BITS-1:0]   shift_reg;
    logic [RESP_BITS-1:0]   shift_next;
    logic                   pull_low_reg;
    logic                   pull_low_next;
    logic                   cmd_valid_reg;
    logic [CMD_FIELD_W-1:0] cmd_code_reg;
    logic [CMD_FIELD_W-1:0] cmd_int_reg;
    logic [MW-1:0]          mod_cnt_reg;
    logic                   mod_phase_reg;
    logic                   emit_pull_reg;

    tofp_stream_if #(.WIDTH(RESP_BITS)) resp_in ();
    tofp_stream_if #(.WIDTH(RESP_BITS)) resp_out ();

    // edge detection on the synchronised lines
    wire sclk_rise  = sclk_s & ~sclk_d_reg;
    wire sclk_fall  = ~sclk_s & sclk_d_reg;
    wire sda_fall   = ~sda_s & sda_d_reg;
    wire sda_moved  = sda_s ^ sda_d_reg;
    wire sclk_held  = sclk_s & sclk_d_reg;
    wire bus_idle   = sclk_s & sda_s;
    // no address phase: any start on the link is meant for this port [R1]
    wire host_start = sda_fall & sclk_held;                    // [R10]
    wire low_over   = ~sclk_s & (low_cnt_reg == LOW_LIMIT_W);  // [R20]
    wire rx_last    = sclk_rise & (bit_cnt_reg == CMD_LAST_W);
    wire tx_last    = sclk_rise & (bit_cnt_reg == RESP_LAST_W);
    // a released bit that reads back low means someone else drives the line
    wire tx_clash   = sclk_rise & ~pull_low_reg & ~sda_s;
    // data moving while the clock stays high inside a command frame
    wire rx_glitch  = sda_moved & sclk_held;
    wire tx_load    = (state_reg == TOFP_IDLE) & ~host_start & resp_out.valid & bus_idle;
    wire mod_wrap   = (mod_cnt_reg == MOD_LAST_W);

    assign resp_in.valid  = resp_valid_i;
    assign resp_in.data   = resp_data_i;
    assign resp_ready_o   = resp_in.ready;
    assign resp_out.ready = tx_load;

    // responses queue here until the link is free [R19]
    tofp_fifo #(
        .WIDTH (RESP_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .flush_i (link_rst_reg),
        .in_s    (resp_in),
        .out_s   (resp_out)
    );

    // clock low-phase watchdog [R20]
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            low_cnt_reg <= '0;
        end else if (sclk_s) begin
            low_cnt_reg <= '0;
        end else if (low_cnt_reg <= LOW_LIMIT_W) begin
            low_cnt_reg <= low_cnt_reg + CW'(1);
        end
    end

    // one-cycle reset request once the low phase exceeds the limit [R5]
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            link_rst_reg <= 1'b0;
        end else begin
            link_rst_reg <= low_over;
        end
    end

    // one state machine serves both directions, so the port is never both [R14]
    always_comb begin
        state_next    = state_reg;
        bit_cnt_next  = bit_cnt_reg;
        shift_next    = shift_reg;
        pull_low_next = pull_low_reg;
        unique case (state_reg)
            TOFP_IDLE: begin
                pull_low_next = 1'b0;                              // [R9]
                if (host_start) begin
                    state_next   = TOFP_RX;
                    bit_cnt_next = BIT_CNT_RST;
                end else if (tx_load) begin
                    state_next    = TOFP_TX_START;
                    shift_next    = resp_out.data;
                    pull_low_next = 1'b1;                          // [R10]
                end
            end
            TOFP_RX: begin
                if (rx_glitch) begin
                    state_next    = TOFP_ERROR;
                    pull_low_next = 1'b1;
                end else if (sclk_rise) begin
                    // sample on rising edge, msb first [R12] [R18]
                    shift_next   = {shift_reg[RESP_BITS-2:0], sda_s};
                    bit_cnt_next = bit_cnt_reg + 5'h01;
                    if (rx_last) begin
                        state_next = TOFP_IDLE;                    // [R11]
                    end
                end
            end
            TOFP_TX_START: begin
                if (sclk_fall) begin
                    // first data bit goes out after the first falling edge [R12] [R19]
                    state_next    = TOFP_TX;
                    bit_cnt_next  = BIT_CNT_RST;
                    pull_low_next = ~shift_reg[RESP_BITS-1];
                    shift_next    = {shift_reg[RESP_BITS-2:0], 1'b0};
                end
            end
            TOFP_TX: begin
                if (tx_clash) begin
                    state_next    = TOFP_ERROR;
                    pull_low_next = 1'b1;
                end else if (tx_last) begin
                    state_next    = TOFP_IDLE;
                    pull_low_next = 1'b0;                          // [R13]
                end else if (sclk_rise) begin
                    bit_cnt_next = bit_cnt_reg + 5'h01;
                end else if (sclk_fall) begin
                    pull_low_next = ~shift_reg[RESP_BITS-1];       // [R12]
                    shift_next    = {shift_reg[RESP_BITS-2:0], 1'b0};
                end
            end
            TOFP_ERROR: begin
                pull_low_next = 1'b1;                              // [R8]
            end
            default: begin
                state_next    = TOFP_ERROR;
                pull_low_next = 1'b1;
            end
        endcase
    end

    // the low-phase reset clears the interface like a hard reset [R5] [R8]
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg    <= TOFP_IDLE;
            bit_cnt_reg  <= BIT_CNT_RST;
            shift_reg    <= RESP_RST;
            pull_low_reg <= 1'b0;
        end else if (low_over) begin
            state_reg    <= TOFP_IDLE;
            bit_cnt_reg  <= BIT_CNT_RST;
            shift_reg    <= RESP_RST;
            pull_low_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            bit_cnt_reg  <= bit_cnt_next;
            shift_reg    <= shift_next;
            pull_low_reg <= pull_low_next;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_d_reg <= 1'b1;
            sda_d_reg  <= 1'b1;
        end else begin
            sclk_d_reg <= sclk_s;
            sda_d_reg  <= sda_s;
        end
    end

    // settings take effect at once and are not kept over a reset [R15] [R18]
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_valid_reg <= 1'b0;
            cmd_code_reg  <= CMD_FIELD_RST;
            cmd_int_reg   <= CMD_FIELD_RST;
        end else if (low_over) begin
            cmd_valid_reg <= 1'b0;
            cmd_code_reg  <= CMD_FIELD_RST;
            cmd_int_reg   <= CMD_FIELD_RST;
        end else begin
            cmd_valid_reg <= (state_reg == TOFP_RX) & rx_last & ~rx_glitch;
            if ((state_reg == TOFP_RX) & rx_last & ~rx_glitch) begin
                cmd_code_reg <= shift_next[CMD_CODE_MSB:CMD_CODE_LSB];
                cmd_int_reg  <= shift_next[CMD_INT_MSB:CMD_INT_LSB];
            end
        end
    end

    // square-wave modulation of the emitter [R16]
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            mod_cnt_reg   <= '0;
            mod_phase_reg <= 1'b0;
            emit_pull_reg <= 1'b0;
        end else begin
            mod_cnt_reg   <= mod_wrap ? '0 : mod_cnt_reg + MW'(1);
            mod_phase_reg <= mod_wrap ? ~mod_phase_reg : mod_phase_reg;
            emit_pull_reg <= illuminate_i & ~link_rst_reg & mod_phase_reg;  // [R17]
        end
    end

    // open-drain pins: output level is always low, the enable pulls [R6] [R7] [R17]
    assign serial_data_line_out_o     = 1'b0;
    assign serial_data_line_oe_o      = pull_low_reg;
    assign emitter_drive_output_out_o = 1'b0;
    assign emitter_drive_output_oe_o  = emit_pull_reg;

    assign cmd_valid_o  = cmd_valid_reg;
    assign cmd_code_o   = cmd_code_reg;
    assign cmd_int_o    = cmd_int_reg;
    assign dev_reset_o  = link_rst_reg;
    assign link_error_o = (state_reg == TOFP_ERROR);
endmodule // tofp_port

// >>> testbench/tofp_port_chk.sv
// concurrent checks on the pins of the range-finder serial port
// assumes it is bound into tofp_port and handed the clock-low timeout
`timescale 1ns/100ps
module tofp_port_chk
    import tofp_pkg::*;
#(
    parameter int SCLK_LOW_LIMIT = 40
) (
    input wire logic                   clock_i,
    input wire logic                   rst_i,
    input wire logic                   sclk_i,
    input wire logic                   illuminate_i,
    input wire logic                   serial_data_line_out_o,
    input wire logic                   serial_data_line_oe_o,
    input wire logic                   emitter_drive_output_out_o,
    input wire logic                   emitter_drive_output_oe_o,
    input wire logic                   cmd_valid_o,
    input wire logic [CMD_FIELD_W-1:0] cmd_code_o,
    input wire logic                   resp_ready_o,
    input wire logic                   dev_reset_o,
    input wire logic                   link_error_o
);
    int   low_cnt_reg;
    logic seen_reg;
    // pin-level low-phase length, saturating just past the check point
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            low_cnt_reg <= 0;
            seen_reg    <= 1'b0;
        end else begin
            low_cnt_reg <= sclk_i ? 0 : low_cnt_reg + int'(low_cnt_reg < SCLK_LOW_LIMIT + 16);
            seen_reg    <= sclk_i ? 1'b0 : (seen_reg | dev_reset_o);
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    a_pins_open_drain: assert property (!serial_data_line_out_o && !emitter_drive_output_out_o)
        else $error("pin driven high");
    a_err_pulls_low: assert property (link_error_o |-> serial_data_line_oe_o)
        else $error("error lock without data held low");
    a_err_until_reset: assert property ($fell(link_error_o) |-> dev_reset_o)
        else $error("error lock left without link reset");
    a_reset_due: assert property (low_cnt_reg == SCLK_LOW_LIMIT + 8 |-> seen_reg || dev_reset_o)
        else $error("no reset after long clock low");
    a_reset_not_early: assert property (dev_reset_o |-> low_cnt_reg > SCLK_LOW_LIMIT)
        else $error("reset before clock-low limit");
    a_reset_one_pulse: assert property (dev_reset_o |=> !dev_reset_o)
        else $error("reset pulse too long");
    a_reset_clears: assert property (dev_reset_o |-> !serial_data_line_oe_o && !link_error_o ##1 resp_ready_o)
        else $error("interface not cleared by reset");
    a_half_duplex: assert property (cmd_valid_o |-> !serial_data_line_oe_o)
        else $error("driving line while receiving");
    a_emit_square: assert property (illuminate_i [*4] |-> emitter_drive_output_oe_o != $past(emitter_drive_output_oe_o))
        else $error("emitter not toggling");
    a_emit_dark: assert property (!illuminate_i [*3] |-> !emitter_drive_output_oe_o)
        else $error("emitter on while dark");
    a_cmd_hold: assert property ($changed(cmd_code_o) |-> cmd_valid_o || cmd_code_o == 4'h0)
        else $error("command field changed without command");
endmodule // tofp_port_chk

bind tofp_port tofp_port_chk #(.SCLK_LOW_LIMIT(SCLK_LOW_LIMIT)) tofp_port_chk_inst (
    .clock_i(clock_i), .rst_i(rst_i), .sclk_i(sclk_i), .illuminate_i(illuminate_i),
    .serial_data_line_out_o(serial_data_line_out_o), .serial_data_line_oe_o(serial_data_line_oe_o),
    .emitter_drive_output_out_o(emitter_drive_output_out_o),
    .emitter_drive_output_oe_o(emitter_drive_output_oe_o), .cmd_valid_o(cmd_valid_o),
    .cmd_code_o(cmd_code_o), .resp_ready_o(resp_ready_o), .dev_reset_o(dev_reset_o),
    .link_error_o(link_error_o)
);

// >>> testbench/tofp_host.sv
// host model of the two-wire link: owns the serial clock, pulls data low only
// assumes the bench resolves the wired data line with a pull-up
`timescale 1ns/100ps
module tofp_host (
    output logic      sclk_o,
    output logic      pull_o,
    input  wire logic data_i
);
    initial begin
        sclk_o = 1'b1;
        pull_o = 1'b0;
    end
    // command frame at 2.5 MHz, well under the link ceiling; glitch flips data in a high phase
    task automatic send_cmd(input logic [7:0] b, input logic glitch);
        #13 pull_o = 1'b1;
        #200;
        for (int i = 7; i >= 0; i--) begin
            sclk_o = 1'b0;
            #125 pull_o = ~b[i];
            #125 sclk_o = 1'b1;
            #75 if (glitch && i == 3) pull_o = ~pull_o;
            #75;
        end
        pull_o = 1'b0;
        #400;
    endtask
    // waits for the device start bit, then clocks out one response word
    task automatic read_resp(output logic [15:0] w);
        int n;
        n = 0;
        while (data_i !== 1'b0 && n < 400) begin
            #50 n++;
        end
        #213;
        for (int i = 15; i >= 0; i--) begin
            sclk_o = 1'b0;
            #250 sclk_o = 1'b1;
            w[i] = data_i;
            #150;
        end
        #400;
    endtask
    task automatic hold_low(input int ns);
        #13 sclk_o = 1'b0;
        #(ns) sclk_o = 1'b1;
        #400;
    endtask
endmodule // tofp_host

// >>> testbench/tofp_port_tb.sv
// self-checking bench for tofp_port with a host model on the serial link
// assumes a 20 MHz clock_i and a shortened clock-low timeout
`timescale 1ns/100ps
module tofp_port_tb;
    import tofp_pkg::*;
    localparam int LOW_LIM = 40;
    logic                   clock_i, rst_i, illuminate_i, resp_valid_i, resp_ready_o;
    logic [RESP_BITS-1:0]   resp_data_i, got;
    logic                   sclk, data_line, host_pull, dev_oe, dev_out, emit_out, emit_oe;
    logic                   cmd_valid_o, dev_reset_o, link_error_o;
    logic [CMD_FIELD_W-1:0] cmd_code_o, cmd_int_o;
    logic [7:0]             cmd_q[$];
    logic [15:0]            resp_q[$];
    logic [3:0]             codes[8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'hD};
    int                     mismatches, samples_checked, seed, cycles, pulses, flips;
    assign data_line = ~((dev_oe & ~dev_out) | host_pull);
    tofp_host tofp_host_inst (.sclk_o(sclk), .pull_o(host_pull), .data_i(data_line));
    tofp_port #(.SCLK_LOW_LIMIT(LOW_LIM)) tofp_port_inst (
        .clock_i(clock_i), .rst_i(rst_i), .sclk_i(sclk), .serial_data_line_in_i(data_line),
        .serial_data_line_out_o(dev_out), .serial_data_line_oe_o(dev_oe),
        .emitter_drive_output_out_o(emit_out), .emitter_drive_output_oe_o(emit_oe),
        .illuminate_i(illuminate_i), .cmd_valid_o(cmd_valid_o), .cmd_code_o(cmd_code_o),
        .cmd_int_o(cmd_int_o), .resp_valid_i(resp_valid_i), .resp_data_i(resp_data_i),
        .resp_ready_o(resp_ready_o), .dev_reset_o(dev_reset_o), .link_error_o(link_error_o)
    );
    task automatic chk_bit(input logic g, input logic e, input string m);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: %s got %b expected %b", $time, m, g, e);
        end
    endtask
    task automatic chk_word(input logic [15:0] g, input logic [15:0] e, input string m);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // offers one word; it counts as taken if ready stood before the edge
    task automatic push(input logic [15:0] w);
        logic r;
        resp_valid_i <= 1'b1;
        resp_data_i  <= w;
        #1 r = resp_ready_o;
        @(posedge clock_i);
        if (r === 1'b1) resp_q.push_back(w);
    endtask
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    // watcher: received commands against the notes, reset pulses, overall limit
    always @(posedge clock_i) begin
        cycles++;
        if (dev_reset_o === 1'b1) pulses++;
        if (cmd_valid_o === 1'b1) begin
            chk_word({8'h00, cmd_code_o, cmd_int_o}, {8'h00, cmd_q.pop_front()}, "command");
        end
        if (cycles == 20000) begin
            mismatches++;
            results();
        end
    end
    initial begin
        seed         = 83239;
        rst_i        = 1'b1;
        illuminate_i = 1'b0;
        resp_valid_i = 1'b0;
        resp_data_i  = 16'h0000;
        repeat (5) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        #1 chk_bit(dev_oe | emit_oe | link_error_o, 1'b0, "idle pins");
        chk_bit(resp_ready_o, 1'b1, "ready after reset");
        foreach (codes[i]) begin
            cmd_q.push_back({codes[i], 4'($random(seed))});
            tofp_host_inst.send_cmd(cmd_q[$], 1'b0);
        end
        chk_word(16'(cmd_q.size()), 16'h0000, "commands left");
        @(posedge clock_i);
        illuminate_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        #1 got[0] = emit_oe;
        flips = 0;
        repeat (16) begin
            @(posedge clock_i);
            #1 flips += int'(emit_oe !== got[0]);
            got[0] = emit_oe;
        end
        chk_word(16'(flips), 16'(16 / MOD_HALF_CYC), "emitter toggles");
        @(posedge clock_i);
        illuminate_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        #1 chk_bit(emit_oe, 1'b0, "emitter dark");
        @(posedge clock_i);
        repeat (RESP_FIFO_DEPTH + 2) push(16'($random(seed)));
        resp_valid_i <= 1'b0;
        #1 chk_bit(resp_ready_o, 1'b0, "fifo full");
        chk_word(16'(resp_q.size()), 16'(RESP_FIFO_DEPTH + 1), "words taken");
        while (resp_q.size() > 0) begin
            tofp_host_inst.read_resp(got);
            chk_word(got, resp_q.pop_front(), "response");
        end
        chk_bit(data_line, 1'b1, "line released");
        pulses = 0;
        tofp_host_inst.send_cmd(8'h8A, 1'b1);
        @(posedge clock_i);
        #1 chk_bit(link_error_o & dev_oe, 1'b1, "error lock");
        // words queued during the lock must vanish with the link reset
        repeat (RESP_FIFO_DEPTH) push(16'($random(seed)));
        resp_valid_i <= 1'b0;
        #1 chk_bit(resp_ready_o, 1'b0, "full in lock");
        tofp_host_inst.hold_low(LOW_LIM * 75);
        resp_q.delete();
        repeat (10) @(posedge clock_i);
        #1 chk_bit(link_error_o | dev_oe, 1'b0, "lock cleared");
        chk_bit(resp_ready_o, 1'b1, "queue flushed");
        chk_word(16'(pulses), 16'h0001, "reset pulses");
        chk_word({12'h000, cmd_code_o}, 16'h0000, "settings lost");
        results();
    end
endmodule // tofp_port_tb
